// ### design/swt_pkg.sv
// Constants and types shared by the sleep wake-up timer
package swt_pkg;
   // Register indices; byte address on APB is four times the index
   localparam logic [7:0] IDX_IRQ_CTRL = 8'hA1;
   localparam logic [7:0] IDX_TIMER_CTRL = 8'hA2;
   localparam logic [7:0] IDX_EVT_LOW = 8'hA3;
   localparam logic [7:0] IDX_EVT_HIGH = 8'hA4;
   localparam logic [7:0] IDX_CNT_LOW = 8'hA5;
   localparam logic [7:0] IDX_CNT_HIGH = 8'hA6;
   localparam logic [7:0] IDX_POWER_CTRL = 8'hB0;
   localparam logic [7:0] IDX_POWER_MODE = 8'hB1;
   localparam logic [7:0] IDX_CPU_IRQ = 8'hB2;

   // Field positions
   localparam int IRQ_EN_BIT = 4;
   localparam int PEND_BIT = 0;
   localparam int CLEAR_BIT = 2;
   localparam int RES_LSB = 0;
   localparam int ENTER_BIT = 0;
   localparam int MODE_LSB = 0;
   localparam int CLK_SEL_BIT = 2;
   localparam int CPU_EN_BIT = 0;
   localparam int CPU_FLAG_BIT = 1;

   // Values after reset and on clear
   localparam logic [15:0] MANT_RESET = 16'h876B;
   localparam logic [30:0] CNT_CLEAR_VAL = 31'h0000_0004;
   localparam logic [7:0] CNT_BYTE_RESET = 8'h00;
   localparam logic [1:0] MODE_DEEP = 2'h3;
   localparam logic [1:0] MODE_PS0 = 2'h0;

   // Slow clock facts, in slow periods and in reference divisions
   localparam int RC_REF_DIV = 750;
   localparam int SLEEP_MIN_PERIODS = 384;
   localparam int RES_STEP_BITS = 5;

   // Power state of the chip as seen by this block
   typedef enum logic [1:0] {
      ST_ACTIVE = 2'b01,
      ST_SLEEP = 2'b10
   } swt_pstate_t;
endpackage

// ### design/swt_sleep_timer.sv
// Sleep wake-up timer with APB register access and power-state control
//
// Function
// - A 31-bit up counter; resolution picks which 16 bits are seen.
// - Counter ticks on the 32.768 kHz crystal or the RC oscillator.
// - Timer runs when active and in power_save_0/1/2, not in the deepest state.
// - A wake event in power_save_0/1/2 returns the chip to active.
// - Event interval is mantissa times 2^(5*resolution) slow periods.
// - Visible count rate follows the resolution setting.
// - RC calibration runs when crystal is up and chip active or PS0.
// - Each wake event sets wake_event_pending.
// - With wake_event_irq_enable set, an event also sets the CPU flag.
// - Interrupt request when CPU flag set and cpu_sleep_irq_enable is 1.
// - Interrupt suppressed when power_mode_select is not 00.
// - Two read-only bytes give the selected slice; both reset to 0x00.
// - Resolution 00..11 selects bits 15:0, 20:5, 25:10, 30:15.
// - Writing 1 to sleep_count_clear sets the counter to 4; reads 0.
// - Mantissa resets to 0x876B; both bytes are writable.
// - Irq enable at bit 4, pending at bit 0; pending cleared by 0.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ns
module swt_sleep_timer (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_xosc32k,
   input wire logic i_rcosc,
   input wire logic i_hs_xosc_on,
   output logic o_irq,
   output logic o_power_save,
   output logic [1:0] o_power_mode,
   output logic o_wake,
   output logic o_rc_cal_enable
);
   import swt_pkg::*;

   // All state of the block
   typedef struct packed {
      logic [30:0] cnt;
      logic [15:0] mant_wr;
      logic [15:0] mant;
      logic mant_upd;
      logic clr_pend;
      logic [1:0] res;
      logic clk_sel;
      logic pend;
      logic irq_en;
      logic cpu_flag;
      logic cpu_en;
      logic [1:0] mode;
      swt_pstate_t pstate;
      logic [2:0] xs;
      logic [2:0] rs;
      logic [1:0] hs;
      logic [7:0] prdata;
      logic wake;
   } swt_state_t;

   swt_state_t s;
   swt_state_t next_s;

   // Pick the visible 16-bit slice of the counter
   function automatic logic [15:0] swt_slice(input logic [30:0] c,
                                             input logic [1:0] r);
      case (r)
         2'h0: swt_slice = c[15:0];
         2'h1: swt_slice = c[20:5];
         2'h2: swt_slice = c[25:10];
         default: swt_slice = c[30:15];
      endcase
   endfunction

   logic [7:0] idx;
   logic mapped;
   logic wr;
   logic setup_rd;
   logic tick;
   logic run;
   logic ev;
   logic [30:0] cnt_inc;
   logic [15:0] view;
   logic [7:0] wd;

   // Address decode; unaligned or out-of-range words are errors
   assign idx = i_paddr[9:2];
   always_comb begin
      case (idx)
         IDX_IRQ_CTRL, IDX_TIMER_CTRL, IDX_EVT_LOW, IDX_EVT_HIGH,
         IDX_CNT_LOW, IDX_CNT_HIGH, IDX_POWER_CTRL, IDX_POWER_MODE,
         IDX_CPU_IRQ: mapped = (i_paddr[11:10] == 2'h0) &&
                               (i_paddr[1:0] == 2'h0);
         default: mapped = 1'b0;
      endcase
   end

   // Zero wait states: read data is latched in the setup cycle
   assign o_pready = i_psel & i_penable;
   assign o_pslverr = i_psel & i_penable & ~mapped;
   assign wr = i_psel & i_penable & i_pwrite & mapped;
   assign setup_rd = i_psel & ~i_penable & ~i_pwrite;
   assign wd = i_pwdata[7:0];

   // Slow edge from the selected, synchronised source
   assign tick = s.clk_sel ? (s.rs[1] & ~s.rs[2])
                           : (s.xs[1] & ~s.xs[2]);
   // Deepest state stops the count
   assign run = !((s.pstate == ST_SLEEP) && (s.mode == MODE_DEEP));
   assign cnt_inc = s.cnt + 31'h1;
   // Compare the slice of the next value, so the interval is exact
   assign ev = tick && run && !s.clr_pend &&
               (swt_slice(cnt_inc, s.res) == s.mant);
   assign view = swt_slice(s.cnt, s.res);

   // Next-state logic
   always_comb begin
      next_s = s;
      next_s.wake = 1'b0;
      // Three flops per slow pin, two for hs; the first is read only by the second
      next_s.xs = {s.xs[1:0], i_xosc32k};
      next_s.rs = {s.rs[1:0], i_rcosc};
      next_s.hs = {s.hs[0], i_hs_xosc_on};

      // Counter and its clear, both aligned to a slow edge
      if (tick && run) begin
         if (s.clr_pend) begin
            next_s.cnt = CNT_CLEAR_VAL;
            next_s.clr_pend = 1'b0;
         end else if (ev) begin
            next_s.cnt = '0;
         end else begin
            next_s.cnt = cnt_inc;
         end
      end

      // Written mantissa reaches the comparator at the next slow edge
      if (tick && s.mant_upd) begin
         next_s.mant = s.mant_wr;
         next_s.mant_upd = 1'b0;
      end

      // Power state: a wake event ends any light sleep
      case (s.pstate)
         ST_ACTIVE: begin
            if (wr && idx == IDX_POWER_CTRL && wd[ENTER_BIT])
               next_s.pstate = ST_SLEEP;
         end
         ST_SLEEP: begin
            if (ev && s.mode != MODE_DEEP) begin
               next_s.pstate = ST_ACTIVE;
               next_s.wake = 1'b1;
            end
         end
         default: next_s.pstate = ST_ACTIVE;
      endcase

      // Register writes
      if (wr) begin
         case (idx)
            IDX_IRQ_CTRL: begin
               next_s.irq_en = wd[IRQ_EN_BIT];
               if (!wd[PEND_BIT])
                  next_s.pend = 1'b0;
            end
            IDX_TIMER_CTRL: begin
               next_s.res = wd[RES_LSB +: 2];
               if (wd[CLEAR_BIT])
                  next_s.clr_pend = 1'b1;
            end
            IDX_EVT_LOW: begin
               next_s.mant_wr[7:0] = wd;
               next_s.mant_upd = 1'b1;
            end
            IDX_EVT_HIGH: begin
               next_s.mant_wr[15:8] = wd;
               next_s.mant_upd = 1'b1;
            end
            IDX_POWER_MODE: begin
               next_s.mode = wd[MODE_LSB +: 2];
               next_s.clk_sel = wd[CLK_SEL_BIT];
            end
            IDX_CPU_IRQ: begin
               next_s.cpu_en = wd[CPU_EN_BIT];
               if (!wd[CPU_FLAG_BIT])
                  next_s.cpu_flag = 1'b0;
            end
            default: ;
         endcase
      end

      // Event flags after writes, so a set wins over a clear
      if (ev) begin
         next_s.pend = 1'b1;
         if (s.irq_en)
            next_s.cpu_flag = 1'b1;
      end

      // Read data captured in the setup cycle
      if (setup_rd) begin
         case (idx)
            IDX_IRQ_CTRL: next_s.prdata = {3'h0, s.irq_en, 3'h0, s.pend};
            IDX_TIMER_CTRL: next_s.prdata = {6'h00, s.res};
            IDX_EVT_LOW: next_s.prdata = s.mant_wr[7:0];
            IDX_EVT_HIGH: next_s.prdata = s.mant_wr[15:8];
            IDX_CNT_LOW: next_s.prdata = view[7:0];
            IDX_CNT_HIGH: next_s.prdata = view[15:8];
            IDX_POWER_CTRL:
               next_s.prdata = {7'h00, s.pstate == ST_SLEEP};
            IDX_POWER_MODE: next_s.prdata = {5'h00, s.clk_sel, s.mode};
            IDX_CPU_IRQ:
               next_s.prdata = {6'h00, s.cpu_flag, s.cpu_en};
            default: next_s.prdata = 8'h00;
         endcase
      end
   end

   // State register
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         s <= '0;
         s.mant_wr <= MANT_RESET;
         s.mant <= MANT_RESET;
         s.pstate <= ST_ACTIVE;
         s.prdata <= CNT_BYTE_RESET;
      end else begin
         s <= next_s;
      end
   end

   // Outputs
   assign o_prdata = {24'h00_0000, s.prdata};
   // Blocked unless power_mode_select is 00
   assign o_irq = s.cpu_flag & s.cpu_en & (s.mode == MODE_PS0);
   assign o_power_save = (s.pstate == ST_SLEEP);
   assign o_power_mode = s.mode;
   assign o_wake = s.wake;
   // Calibration freezes in PS1/PS2 so the last result is kept
   assign o_rc_cal_enable = s.hs[1] &
      ((s.pstate == ST_ACTIVE) || (s.mode == MODE_PS0));

   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);

   sequence s_event;
      ev;
   endsequence

   sequence s_clear_tick;
      s.clr_pend && tick && run;
   endsequence

   a_clear_to_four: assert property (
      s_clear_tick |=> s.cnt == 31'h0000_0004)
      else $error("counter not set to 4 after clear");

   a_event_restart: assert property (
      s_event |=> s.cnt == 31'h0 && s.pend)
      else $error("count did not restart at event");

   a_pend_set: assert property (s_event |=> s.pend)
      else $error("pending flag not set by event");

   a_cpu_flag_set: assert property (
      s_event and s.irq_en |=> s.cpu_flag)
      else $error("cpu flag not set with enable");

   a_irq_gate: assert property (
      o_irq |-> s.mode == 2'h0 && s.cpu_en && s.cpu_flag)
      else $error("interrupt raised while blocked");

   a_wake_active: assert property (
      s_event and o_power_save and s.mode != 2'h3
      |=> !o_power_save && o_wake ##1 !o_wake)
      else $error("wake event did not return to active");

   a_deep_hold: assert property (
      o_power_save && s.mode == 2'h3 |=> $stable(s.cnt))
      else $error("counter moved in deepest state");

   a_count_step: assert property (
      tick && run && !s.clr_pend && !ev
      |=> s.cnt == $past(s.cnt) + 31'h1)
      else $error("counter did not step by one");

   a_mant_sync: assert property (
      s.mant_upd && tick && !wr |=> s.mant == $past(s.mant_wr))
      else $error("mantissa not taken at slow edge");

   a_mant_wait: assert property (
      s.mant_upd && !tick |=> s.mant == $past(s.mant))
      else $error("mantissa changed between slow edges");

   a_read_low: assert property (
      setup_rd && idx == IDX_CNT_LOW
      |=> o_prdata == {24'h00_0000, $past(view[7:0])})
      else $error("count low byte read wrong");

   a_cal_hold: assert property (
      o_power_save && s.mode != 2'h0 |-> !o_rc_cal_enable)
      else $error("calibration ran in deeper sleep");
endmodule

// ### tb/sleep_wakeup_timer_tb.sv
// Self-checking bench for the sleep wake-up timer
`timescale 1ns/1ns
module sleep_wakeup_timer_tb;
   import swt_pkg::*;
   typedef struct packed {
      logic wr;
      logic [7:0] idx;
      logic [7:0] wd;
      logic [7:0] exp;
   } swt_row_t;
   logic i_clk = 1'b0;
   logic i_srst = 1'b1;
   logic i_psel = 1'b0;
   logic i_penable = 1'b0;
   logic i_pwrite = 1'b0;
   logic [11:0] i_paddr = 12'h000;
   logic [31:0] i_pwdata = 32'h0000_0000;
   logic i_xosc32k = 1'b0;
   logic i_rcosc = 1'b0;
   logic i_hs_xosc_on = 1'b1;
   logic [31:0] o_prdata;
   logic o_pready, o_pslverr, o_irq, o_power_save, o_wake, o_rc_cal_enable;
   logic [1:0] o_power_mode;
   int num_errors = 0;
   int samples_checked = 0;
   logic use_rc = 1'b0;
   logic wake_seen = 1'b0;
   logic [31:0] rd;
   logic err;
   // Reset values first, then writes read back through the same loop
   swt_row_t rows [11] = '{
      '{1'b0, IDX_IRQ_CTRL, 8'h00, 8'h00},
      '{1'b0, IDX_TIMER_CTRL, 8'h00, 8'h00},
      '{1'b0, IDX_EVT_LOW, 8'h00, 8'h6B}, '{1'b0, IDX_EVT_HIGH, 8'h00, 8'h87},
      '{1'b0, IDX_CNT_LOW, 8'h00, 8'h00}, '{1'b0, IDX_CNT_HIGH, 8'h00, 8'h00},
      '{1'b1, IDX_EVT_LOW, 8'h05, 8'h05}, '{1'b1, IDX_EVT_HIGH, 8'h00, 8'h00},
      '{1'b1, IDX_TIMER_CTRL, 8'h04, 8'h00},
      '{1'b1, IDX_IRQ_CTRL, 8'h11, 8'h10},
      '{1'b1, IDX_CPU_IRQ, 8'h03, 8'h01}};

   swt_sleep_timer swt_sleep_timer_inst (.i_clk(i_clk), .i_srst(i_srst),
      .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
      .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
      .o_pready(o_pready), .o_pslverr(o_pslverr), .i_xosc32k(i_xosc32k),
      .i_rcosc(i_rcosc), .i_hs_xosc_on(i_hs_xosc_on), .o_irq(o_irq),
      .o_power_save(o_power_save), .o_power_mode(o_power_mode),
      .o_wake(o_wake), .o_rc_cal_enable(o_rc_cal_enable));

   // Free-running system clock, 10 ns period
   always #5 i_clk = ~i_clk;

   task automatic stop_test;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk_val(input string name, input logic [31:0] e,
                          input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", name, e, g);
      end
   endtask

   task automatic chk_bit(input string name, input logic e, input logic g);
      samples_checked++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected %s expected %b seen %b", name, e, g);
      end
   endtask

   // One APB transfer; the request holds until pready is seen at an edge
   task automatic apb(input logic wr, input logic [7:0] idx,
                      input logic [31:0] wd, output logic [31:0] q,
                      output logic e);
      int n;
      n = 0;
      @(posedge i_clk);
      i_psel <= 1'b1;
      i_pwrite <= wr;
      i_paddr <= {2'b00, idx, 2'b00};
      i_pwdata <= wd;
      @(posedge i_clk);
      i_penable <= 1'b1;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         num_errors++;
         stop_test();
      end
      q = o_prdata;
      e = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      apb(1'b1, idx, {24'h000000, d}, rd, err);
   endtask

   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
      apb(1'b0, idx, 32'h0000_0000, rd, err);
      chk_val("read data", {24'h000000, e}, rd);
   endtask

   // Slow clock pulses; the pin stays still long enough for the 3-flop sync
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge i_clk);
         if (use_rc) i_rcosc <= 1'b1;
         else i_xosc32k <= 1'b1;
         // Wake pulse is looked at mid-cycle, away from its launching edge
         repeat (6) begin
            @(negedge i_clk);
            if (o_wake === 1'b1) wake_seen = 1'b1;
         end
         @(posedge i_clk);
         i_xosc32k <= 1'b0;
         i_rcosc <= 1'b0;
         repeat (6) @(posedge i_clk);
      end
      @(negedge i_clk);
   endtask

   initial begin
      repeat (2) @(posedge i_clk);
      i_srst <= 1'b0;
      @(negedge i_clk);
      chk_bit("power_save", 1'b0, o_power_save);
      chk_bit("irq", 1'b0, o_irq);
      foreach (rows[i]) begin
         if (rows[i].wr) wr(rows[i].idx, rows[i].wd);
         rd_chk(rows[i].idx, rows[i].exp);
      end
      // Unmapped index is refused with zero data
      apb(1'b0, 8'h10, 32'h0000_0000, rd, err);
      chk_bit("pslverr", 1'b1, err);
      chk_val("unmapped data", 32'h0000_0000, rd);
      tick(1);
      rd_chk(IDX_CNT_LOW, 8'h04);
      tick(1);
      rd_chk(IDX_CNT_LOW, 8'h00);
      rd_chk(IDX_IRQ_CTRL, 8'h11);
      rd_chk(IDX_CPU_IRQ, 8'h03);
      @(negedge i_clk);
      chk_bit("irq", 1'b1, o_irq);
      wr(IDX_POWER_MODE, 8'h01);
      @(negedge i_clk);
      chk_bit("irq", 1'b0, o_irq);
      chk_val("power_mode", 32'h0000_0001, {30'h0, o_power_mode});
      wr(IDX_POWER_MODE, 8'h00);
      wr(IDX_IRQ_CTRL, 8'h10);
      rd_chk(IDX_IRQ_CTRL, 8'h10);
      wr(IDX_CPU_IRQ, 8'h01);
      @(negedge i_clk);
      chk_bit("irq", 1'b0, o_irq);
      // Sleep in a light state and wake after exactly five slow periods
      // A short sleep uses power_save_1; power_save_2 needs 384 periods
      wr(IDX_POWER_MODE, 8'h01);
      wr(IDX_POWER_CTRL, 8'h01);
      @(negedge i_clk);
      chk_bit("power_save", 1'b1, o_power_save);
      chk_bit("rc_cal", 1'b0, o_rc_cal_enable);
      wake_seen = 1'b0;
      tick(4);
      chk_bit("power_save", 1'b1, o_power_save);
      tick(1);
      chk_bit("wake", 1'b1, wake_seen);
      chk_bit("power_save", 1'b0, o_power_save);
      chk_bit("rc_cal", 1'b1, o_rc_cal_enable);
      // RC clock, big mantissa, clear, then count asleep in power_save_0
      wr(IDX_EVT_HIGH, 8'hFF);
      wr(IDX_EVT_LOW, 8'hFF);
      wr(IDX_POWER_MODE, 8'h04);
      use_rc = 1'b1;
      wr(IDX_TIMER_CTRL, 8'h04);
      tick(2);
      // Entry just after a slow edge; the count of 5 made while active carries on asleep
      wr(IDX_POWER_CTRL, 8'h01);
      @(negedge i_clk);
      chk_bit("power_save", 1'b1, o_power_save);
      chk_bit("rc_cal", 1'b1, o_rc_cal_enable);
      tick(31);
      rd_chk(IDX_CNT_LOW, 8'h24);
      wr(IDX_TIMER_CTRL, 8'h01);
      rd_chk(IDX_CNT_LOW, 8'h01);
      rd_chk(IDX_CNT_HIGH, 8'h00);
      wr(IDX_TIMER_CTRL, 8'h03);
      rd_chk(IDX_CNT_LOW, 8'h00);
      // Mantissa above the count: clear, wait two edges, then write it
      wr(IDX_TIMER_CTRL, 8'h04);
      tick(2);
      wr(IDX_EVT_HIGH, 8'h00);
      wr(IDX_EVT_LOW, 8'h10);
      wr(IDX_CPU_IRQ, 8'h01);
      wake_seen = 1'b0;
      tick(10);
      chk_bit("power_save", 1'b1, o_power_save);
      tick(1);
      chk_bit("wake", 1'b1, wake_seen);
      chk_bit("power_save", 1'b0, o_power_save);
      chk_bit("irq", 1'b1, o_irq);
      // Deepest state freezes the counter
      wr(IDX_TIMER_CTRL, 8'h00);
      wr(IDX_POWER_MODE, 8'h07);
      wr(IDX_POWER_CTRL, 8'h01);
      tick(3);
      chk_val("power_mode", 32'h0000_0003, {30'h0, o_power_mode});
      chk_bit("power_save", 1'b1, o_power_save);
      rd_chk(IDX_CNT_LOW, 8'h00);
      stop_test();
   end
endmodule
